// ===== imz_map.svh
/*
 * Register offsets, field positions, reset values, carrier constants and
 * FIFO sizing of the interpolating modulator with zero stuffing.
 * Assumes that it is included by its bare name, before any module that uses it.
 */
`ifndef IMZ_MAP_SVH
`define IMZ_MAP_SVH

`define IMZ_ADDR_W        5
`define IMZ_CTRL_ADDR     5'h01
`define IMZ_STAT_ADDR     5'h1F
`define IMZ_CTRL_RESET    8'h00
`define IMZ_CTRL_RMASK    8'hFE

`define IMZ_RATE_HI       7
`define IMZ_RATE_LO       6
`define IMZ_MOD_HI        5
`define IMZ_MOD_LO        4
`define IMZ_ZS_BIT        3
`define IMZ_CMIX_BIT      2
`define IMZ_NEG_BIT       1
`define IMZ_UNDER_BIT     0

`define IMZ_MOD_OFF       2'h0
`define IMZ_MOD_FS2       2'h1
`define IMZ_MOD_FS4       2'h2
`define IMZ_MOD_FS8       2'h3

`define IMZ_SAMPLE_W      16
`define IMZ_MIDSCALE      16'h8000
`define IMZ_COEF_ONE      18'sh10000
`define IMZ_COEF_R2       18'sh0B505
`define IMZ_FIFO_DEPTH    32

`endif

// ===== imz_pkg.sv
/*
 * Types shared by the modulator modules.
 * Assumes imz_map.svh for the widths that these types carry.
 */
`include "imz_map.svh"

package imz_pkg;
    typedef logic signed [`IMZ_SAMPLE_W-1:0] imz_sample_t;   // Two's complement sample
    typedef logic signed [17:0]              imz_coef_t;     // Carrier value, 1.0 = 2^16
    typedef enum logic [1:0] {
        IMZ_RATE_1X,
        IMZ_RATE_2X,
        IMZ_RATE_4X,
        IMZ_RATE_8X
    } imz_rate_t;                                             // Interpolation rate code
endpackage : imz_pkg

// ===== imz_stream_if.sv
/*
 * Valid/ready stream carrier between the modulator's own modules.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface imz_stream_if #(
    parameter int WIDTH = 32                 // Payload width
);
    logic             valid;                 // Payload present
    logic             ready;                 // Taker can accept
    logic [WIDTH-1:0] data;                  // Payload

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : imz_stream_if

`default_nettype wire

// ===== imz_fifo.sv
/*
 * Synchronous FIFO with registered full and empty flags.
 * Assumes both stream ends run on clk_sys_i; depth is a power of two.
 */
`timescale 1ns/100ps
`default_nettype none

module imz_fifo #(
    parameter int WIDTH = 32,                       // Word width
    parameter int DEPTH = 32                        // Word count
) (
    input  wire logic   clk_sys_i,                  // System clock
    input  wire logic   sys_rst_i,                  // Synchronous reset, high
    imz_stream_if.snk   fill,                       // Filling side
    imz_stream_if.src   drain                       // Draining side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];                  // Storage array
    logic [AW-1:0]    wr_ptr,    next_wr_ptr;       // Write index
    logic [AW-1:0]    rd_ptr,    next_rd_ptr;       // Read index
    logic [AW:0]      count,     next_count;        // Words held
    logic             full_q,    next_full;         // Registered full
    logic             empty_q,   next_empty;        // Registered empty
    logic             room_q,    next_room;         // Registered not-full, drives ready
    logic             push;                         // Word enters
    logic             pop;                          // Word leaves

    // Flags come from flops so that ready and valid carry no logic depth
    assign fill.ready  = room_q;
    assign drain.valid = ~empty_q;
    assign drain.data  = mem[rd_ptr];
    assign push        = fill.valid & ~full_q;
    assign pop         = drain.ready & ~empty_q;

    // Next pointers and occupancy
    always_comb begin
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
        next_full  = (next_count == (AW+1)'(DEPTH));
        next_empty = (next_count == '0);
        next_room  = !next_full;
    end

    // Register pointers and flags
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
            room_q  <= 1'b1;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            count   <= next_count;
            full_q  <= next_full;
            empty_q <= next_empty;
            room_q  <= next_room;
        end
    end

    // Storage has no reset; contents are only read while valid
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (full_q && fill.valid && !pop) |=> full_q && count == (AW+1)'(DEPTH))
        else $error("fifo count moved while full");
endmodule : imz_fifo

`default_nettype wire

// ===== imz_modulator.sv
/*
 * Transmit datapath: input FIFO, interpolation stage, real or complex
 * digital modulator, zero stuffing, and the control register port.
 * Assumes the sample source and register master run on clk_sys_i, which is
 * the DAC sample clock; one converter word per channel leaves every cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "imz_map.svh"

module imz_modulator #(
    parameter logic [1:0] MOD_OFF = `IMZ_MOD_OFF,        // Modulation field: disabled
    parameter logic [1:0] MOD_FS2 = `IMZ_MOD_FS2,        // Modulation field: half rate
    parameter logic [1:0] MOD_FS4 = `IMZ_MOD_FS4,        // Modulation field: quarter rate
    parameter logic [1:0] MOD_FS8 = `IMZ_MOD_FS8,        // Modulation field: eighth rate
    parameter int         DEPTH   = `IMZ_FIFO_DEPTH      // Input FIFO depth
) (
    input  wire logic                   clk_sys_i,       // DAC sample clock
    input  wire logic                   sys_rst_i,       // Synchronous reset, high
    input  wire logic                   reg_wr_i,        // Register write strobe
    input  wire logic [`IMZ_ADDR_W-1:0] reg_addr_i,      // Register address
    input  wire logic [7:0]             reg_wdata_i,     // Register write data
    output logic      [7:0]             reg_rdata_o,     // Register read data
    input  wire logic                   in_valid_i,      // I/Q pair offered
    output logic                        in_ready_o,      // I/Q pair accepted
    input  wire logic [`IMZ_SAMPLE_W-1:0] in_i_i,        // I sample, two's complement
    input  wire logic [`IMZ_SAMPLE_W-1:0] in_q_i,        // Q sample, two's complement
    output logic      [`IMZ_SAMPLE_W-1:0] dac_i_o,       // I converter word, offset binary
    output logic      [`IMZ_SAMPLE_W-1:0] dac_q_o        // Q converter word, offset binary
);
    localparam int SW = `IMZ_SAMPLE_W;

    imz_stream_if #(.WIDTH(2*SW)) fill_if ();            // Source into FIFO
    imz_stream_if #(.WIDTH(2*SW)) drain_if ();           // FIFO into datapath

    logic [7:0]          ctrl,       next_ctrl;          // Mode control register
    logic                underrun,   next_underrun;      // Sticky starvation flag
    logic [7:0]          rdata,      next_rdata;         // Read data register
    logic                stuff_ph,   next_stuff_ph;      // High on midscale slots
    logic [2:0]          sub_cnt,    next_sub_cnt;       // Output slot within sample
    logic [2:0]          ph,         next_ph;            // Carrier phase index
    imz_pkg::imz_sample_t hold_i,    next_hold_i;        // Held I sample
    imz_pkg::imz_sample_t hold_q,    next_hold_q;        // Held Q sample
    logic [SW-1:0]       dac_i,      next_dac_i;         // I output register
    logic [SW-1:0]       dac_q,      next_dac_q;         // Q output register

    imz_pkg::imz_rate_t  rate;                           // Decoded rate
    logic [1:0]          mod_sel;                        // Modulation field
    logic                zs_en;                          // Zero stuffing enable
    logic                cplx;                           // Complex mode in force
    logic                data_slot;                      // Slot carries filter output
    logic                take;                           // Slot starts a new sample
    logic [2:0]          sub_last;                       // Last slot index
    imz_pkg::imz_sample_t cur_i;                         // Sample now modulated, I
    imz_pkg::imz_sample_t cur_q;                         // Sample now modulated, Q
    logic [2:0]          k_sin;                          // Eighth-circle angle index
    imz_pkg::imz_coef_t  c_sin;                          // Sine at angle
    imz_pkg::imz_coef_t  c_cos;                          // Cosine at angle
    imz_pkg::imz_coef_t  c_real;                         // Real-mode carrier
    imz_pkg::imz_coef_t  c_s;                            // Signed sine for rotation
    logic signed [33:0]  p_ic, p_qs, p_is, p_qc;         // Partial products
    logic signed [34:0]  acc_i, acc_q;                   // Modulator sums
    imz_pkg::imz_sample_t mod_i, mod_q;                  // Modulator outputs

    // Eighth-circle sine, 1.0 = 2^16
    function automatic imz_pkg::imz_coef_t sin8(input logic [2:0] k);
        case (k)
            3'h0:    sin8 = '0;
            3'h1:    sin8 = `IMZ_COEF_R2;
            3'h2:    sin8 = `IMZ_COEF_ONE;
            3'h3:    sin8 = `IMZ_COEF_R2;
            3'h4:    sin8 = '0;
            3'h5:    sin8 = -`IMZ_COEF_R2;
            3'h6:    sin8 = -`IMZ_COEF_ONE;
            default: sin8 = -`IMZ_COEF_R2;
        endcase
    endfunction : sin8

    // Scale a sum back by 2^16 and clamp to the sample range
    function automatic imz_pkg::imz_sample_t sat16(input logic signed [34:0] v);
        logic signed [18:0] s;
        s = v[34:16];
        if (s > 19'sd32767) begin
            sat16 = 16'sh7FFF;
        end else if (s < -19'sd32768) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = s[15:0];
        end
    endfunction : sat16

    imz_fifo #(
        .WIDTH (2*SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .fill      (fill_if),
        .drain     (drain_if)
    );

    assign fill_if.valid = in_valid_i;
    assign fill_if.data  = {in_i_i, in_q_i};
    assign in_ready_o    = fill_if.ready;                // Registered not-full flag
    assign drain_if.ready = take;

    // Field decode
    assign rate    = imz_pkg::imz_rate_t'(ctrl[`IMZ_RATE_HI:`IMZ_RATE_LO]);
    assign mod_sel = ctrl[`IMZ_MOD_HI:`IMZ_MOD_LO];
    assign zs_en   = ctrl[`IMZ_ZS_BIT];
    // No quadrature pair exists at half rate; fall back to real modulation
    assign cplx    = ctrl[`IMZ_CMIX_BIT] &&
                     (mod_sel == MOD_FS4 || mod_sel == MOD_FS8);

    // Slot sequencing: stuffing splits each cycle pair into data then midscale
    always_comb begin
        data_slot = !zs_en || !stuff_ph;
        case (rate)
            imz_pkg::IMZ_RATE_1X: sub_last = 3'h0;
            imz_pkg::IMZ_RATE_2X: sub_last = 3'h1;
            imz_pkg::IMZ_RATE_4X: sub_last = 3'h3;
            default:              sub_last = 3'h7;
        endcase
        take          = data_slot && (sub_cnt == 3'h0);
        next_stuff_ph = zs_en ? ~stuff_ph : 1'b0;
        next_sub_cnt  = sub_cnt;
        next_ph       = ph;
        if (data_slot) begin
            // A rate change mid-sample wraps at once instead of overrunning
            next_sub_cnt = (sub_cnt >= sub_last) ? 3'h0 : sub_cnt + 3'h1;
            next_ph      = ph + 3'h1;
        end
    end

    // Interpolation stage: hold each sample across its output slots.
    // Filter taps are not modelled; the held sample stands in for them.
    always_comb begin
        next_hold_i = hold_i;
        next_hold_q = hold_q;
        if (take) begin
            if (drain_if.valid) begin
                next_hold_i = drain_if.data[2*SW-1:SW];
                next_hold_q = drain_if.data[SW-1:0];
            end else begin
                next_hold_i = '0;                        // Starved: send silence
                next_hold_q = '0;
            end
        end
        cur_i = take ? next_hold_i : hold_i;
        cur_q = take ? next_hold_q : hold_q;
    end

    // Carrier selection from the phase index
    always_comb begin
        case (mod_sel)
            MOD_FS2: k_sin = {ph[0], 2'b00};
            MOD_FS4: k_sin = {ph[1:0], 1'b0};
            MOD_FS8: k_sin = ph;
            default: k_sin = 3'h0;
        endcase
        c_sin = sin8(k_sin);
        c_cos = sin8(k_sin + 3'h2);
        case (mod_sel)
            MOD_FS2: c_real = c_cos;
            MOD_FS4: c_real = c_sin;
            MOD_FS8: c_real = c_sin;
            default: c_real = `IMZ_COEF_ONE;
        endcase
        c_s = ctrl[`IMZ_NEG_BIT] ? -c_sin : c_sin;
    end

    // Modulator: two real products or one complex rotation
    always_comb begin
        p_ic  = cur_i * (cplx ? c_cos : c_real);
        p_qc  = cur_q * (cplx ? c_cos : c_real);
        p_qs  = cur_q * c_s;
        p_is  = cur_i * c_s;
        acc_i = {p_ic[33], p_ic};
        acc_q = {p_qc[33], p_qc};
        if (cplx) begin
            acc_i = {p_ic[33], p_ic} - {p_qs[33], p_qs};
            acc_q = {p_is[33], p_is} + {p_qc[33], p_qc};
        end
        mod_i = sat16(acc_i);
        mod_q = sat16(acc_q);
        // Midscale replaces the modulated word only at the converter edge
        next_dac_i = data_slot ? {~mod_i[SW-1], mod_i[SW-2:0]} : `IMZ_MIDSCALE;
        next_dac_q = data_slot ? {~mod_q[SW-1], mod_q[SW-2:0]} : `IMZ_MIDSCALE;
    end

    // Register port: write control, clear starvation by writing one
    always_comb begin
        next_ctrl     = ctrl;
        next_underrun = underrun;
        if (reg_wr_i && reg_addr_i == `IMZ_CTRL_ADDR) begin
            next_ctrl = reg_wdata_i & `IMZ_CTRL_RMASK;
        end
        if (reg_wr_i && reg_addr_i == `IMZ_STAT_ADDR && reg_wdata_i[`IMZ_UNDER_BIT]) begin
            next_underrun = 1'b0;
        end
        // A new starvation in the clearing cycle is kept
        if (take && !drain_if.valid) begin
            next_underrun = 1'b1;
        end
        case (reg_addr_i)
            `IMZ_CTRL_ADDR: next_rdata = ctrl;
            `IMZ_STAT_ADDR: next_rdata = {6'h00, ~drain_if.valid, underrun};
            default:        next_rdata = 8'h00;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl     <= `IMZ_CTRL_RESET;
            underrun <= 1'b0;
            rdata    <= 8'h00;
            stuff_ph <= 1'b0;
            sub_cnt  <= 3'h0;
            ph       <= 3'h0;
            hold_i   <= '0;
            hold_q   <= '0;
            dac_i    <= `IMZ_MIDSCALE;
            dac_q    <= `IMZ_MIDSCALE;
        end else begin
            ctrl     <= next_ctrl;
            underrun <= next_underrun;
            rdata    <= next_rdata;
            stuff_ph <= next_stuff_ph;
            sub_cnt  <= next_sub_cnt;
            ph       <= next_ph;
            hold_i   <= next_hold_i;
            hold_q   <= next_hold_q;
            dac_i    <= next_dac_i;
            dac_q    <= next_dac_q;
        end
    end

    assign reg_rdata_o = rdata;
    assign dac_i_o     = dac_i;
    assign dac_q_o     = dac_q;

    a_stuff_midscale: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (zs_en && stuff_ph) |=> (dac_i == 16'h8000 && dac_q == 16'h8000))
        else $error("midscale slot did not output midscale");

    a_stuff_alternates: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (zs_en && $past(zs_en)) |-> (stuff_ph != $past(stuff_ph)))
        else $error("stuff phase did not toggle");

    // A rate change leaves the slot counter mid-count for one cycle
    a_bypass_every_slot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (rate == imz_pkg::IMZ_RATE_1X && !zs_en && $past(rate) == imz_pkg::IMZ_RATE_1X &&
         !$past(zs_en)) |-> take)
        else $error("bypass rate missed a sample slot");

    a_rate_two_gap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (take && rate == imz_pkg::IMZ_RATE_2X && !zs_en) ##1
        (rate == imz_pkg::IMZ_RATE_2X && !zs_en) |-> !take ##1 take)
        else $error("two times rate spacing wrong");

    a_rate_four_gap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (take && rate == imz_pkg::IMZ_RATE_4X && !zs_en) ##1
        (rate == imz_pkg::IMZ_RATE_4X && !zs_en)[*3] |=> take)
        else $error("four times rate spacing wrong");

    a_eighth_peak: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mod_sel == MOD_FS8 && !cplx && data_slot && ph == 3'h2 && cur_i == 16'sh4000)
        |=> dac_i == 16'hC000)
        else $error("eighth rate carrier peak wrong");

    a_half_rate_sign: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mod_sel == MOD_FS2 && data_slot && ph[0] && cur_i == 16'sh1000)
        |=> dac_i == 16'h7000)
        else $error("half rate carrier not full scale negative");

    a_mod_off_pass: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mod_sel == MOD_OFF && data_slot) |=> dac_i == {~$past(cur_i[15]), $past(cur_i[14:0])})
        else $error("disabled modulation altered sample");

    a_phase_restart: assert property (@(posedge clk_sys_i)
        ($past(sys_rst_i) && !sys_rst_i) |-> (ph == 3'h0 && sub_cnt == 3'h0))
        else $error("carrier phase not zero after reset");

    a_cplx_zero_phase: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cplx && data_slot && ph == 3'h0)
        |=> (dac_i == {~$past(cur_i[15]), $past(cur_i[14:0])} &&
             dac_q == {~$past(cur_q[15]), $past(cur_q[14:0])}))
        else $error("complex rotation at phase zero not identity");

    // Quarter-rate negative rotation at the sine peak negates I into Q
    a_cplx_neg_quarter: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cplx && ctrl[`IMZ_NEG_BIT] && mod_sel == MOD_FS4 && data_slot && ph[1:0] == 2'h1 &&
         cur_i == 16'sh1000)
        |=> dac_q == 16'h7000)
        else $error("negative rotation sign wrong");

    // Set beats a same-cycle clear, so a starved slot always leaves the flag up
    a_starve_sets_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (take && !drain_if.valid) |=> underrun)
        else $error("starved slot did not set underrun");
endmodule : imz_modulator

`default_nettype wire

// ===== imz_src_model.sv
/*
 * Baseband I/Q sample source standing in front of the modulator's stream input.
 * Assumes the bench supplies the values to send and shares clk_sys_i with the design.
 */
`timescale 1ns/100ps
`default_nettype none

module imz_src_model (
    input  wire logic        clk_sys_i,  // Sample clock
    input  wire logic        sys_rst_i,  // Synchronous reset, high
    input  wire logic        run_i,      // Offer samples
    input  wire logic        slow_i,     // Idle two cycles after each pair
    input  wire logic [15:0] set_i_i,    // I value to send
    input  wire logic [15:0] set_q_i,    // Q value to send
    input  wire logic        ready_i,    // Taker accepts
    output logic             valid_o,    // Pair offered
    output logic      [15:0] i_o,        // I sample
    output logic      [15:0] q_o         // Q sample
);
    logic gap;  // Idle slot owed in slow mode

    // An offer is held until taken; idle lines toggle every cycle so that a
    // taker sampling outside a transfer never sees plausible stale data
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            valid_o <= 1'b0;
            gap     <= 1'b0;
            i_o     <= 16'hFFFF;
            q_o     <= 16'hFFFF;
        end else if (valid_o && ready_i && run_i && !slow_i) begin
            i_o <= set_i_i;
            q_o <= set_q_i;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            gap     <= slow_i;
            i_o     <= ~i_o;
            q_o     <= ~q_o;
        end else if (!valid_o && run_i && !gap) begin
            valid_o <= 1'b1;
            i_o     <= set_i_i;
            q_o     <= set_q_i;
        end else if (!valid_o) begin
            gap <= 1'b0;
            i_o <= ~i_o;
            q_o <= ~q_o;
        end
    end
endmodule : imz_src_model

`default_nettype wire

// ===== test_imz_modulator.sv
/*
 * Self-checking bench of the modulator: registers, real, stuffed and complex modes, flow.
 * Assumes the design files and imz_map.svh are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "imz_map.svh"

module test_imz_modulator;
    logic        clk_sys_i, sys_rst_i, reg_wr, run, slow, valid, ready;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata, rdata;
    logic [15:0] si, sq, in_i, in_q, dac_i, dac_q;
    logic [15:0] cap_i[16], cap_q[16];  // Captured converter words
    int          err_count = 0, total_checks = 0, cyc = 0;
    int          sin8[8] = '{0, 46341, 65536, 46341, 0, -46341, -65536, -46341};

    // Small FIFO keeps refill and drain waits short
    imz_modulator #(.DEPTH(4)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata), .in_valid_i(valid), .in_ready_o(ready), .in_i_i(in_i),
        .in_q_i(in_q), .dac_i_o(dac_i), .dac_q_o(dac_q));
    imz_src_model src_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .run_i(run),
        .slow_i(slow), .set_i_i(si), .set_q_i(sq), .ready_i(ready), .valid_o(valid),
        .i_o(in_i), .q_o(in_q));

    // Free running 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Hang guard: the whole run needs about 3700 cycles
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr   <= 1'b0;
        reg_addr <= `IMZ_CTRL_ADDR;
    endtask : wr

    task rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        reg_addr <= a;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1 check({8'h00, rdata}, {8'h00, exp}, what);
    endtask : rd

    // Product scaled back by 2^16, then turned into offset binary
    function automatic logic [15:0] mul2(int a, int c1, int b, int c2);
        return 16'((a * c1 + b * c2) >>> 16) ^ 16'h8000;
    endfunction : mul2

    // Configure, stream a constant pair, then look for one carrier phase
    // that explains sixteen consecutive output words on both channels
    task t_mode(input logic [1:0] rate, input logic [1:0] md, input logic zs,
                input logic cm, input logic ng, input int vi, input int vq);
        int st, k, s, stp, sn, cs, c, hits;
        logic [15:0] ei, eq;
        bit ok;
        wr(`IMZ_CTRL_ADDR, {rate, md, zs, cm, ng, 1'b0});
        @(posedge clk_sys_i);
        si  <= 16'(vi);
        sq  <= 16'(vq);
        run <= 1'b1;
        // Stale words of the last mode drain in up to 96 cycles at 8x stuffed
        repeat (120) @(posedge clk_sys_i);
        for (k = 0; k < 16; k++) begin
            @(posedge clk_sys_i);
            #1 cap_i[k] = dac_i;
            cap_q[k] = dac_q;
        end
        stp = (md == 2'h1) ? 4 : (md == 2'h2) ? 2 : 1;
        hits = 0;
        for (st = 0; st < 16; st++) begin
            ok = 1'b1;
            for (k = 0; k < 16; k++) begin
                s = zs ? (st + k) / 2 : st + k;
                sn = sin8[(stp * s) % 8];
                cs = sin8[(stp * s + 2) % 8];
                if (zs && ((st + k) % 2 == 1)) begin
                    ei = 16'h8000;
                    eq = 16'h8000;
                end else if (cm && md >= 2'h2) begin
                    sn = ng ? -sn : sn;
                    ei = mul2(vi, cs, vq, -sn);
                    eq = mul2(vi, sn, vq, cs);
                end else begin
                    c = (md == 2'h0) ? 65536 : (md == 2'h1) ? cs : sn;
                    ei = mul2(vi, c, 0, 0);
                    eq = mul2(vq, c, 0, 0);
                end
                if (cap_i[k] !== ei || cap_q[k] !== eq) ok = 1'b0;
            end
            if (ok) hits++;
        end
        check({15'h0, hits > 0}, 16'h0001, "carrier pattern");
    endtask : t_mode

    task t_regs;
        check(dac_i, 16'h8000, "reset midscale");
        check({15'h0, ready}, 16'h0001, "ready after reset");
        rd(`IMZ_CTRL_ADDR, 8'h00, "control reset");
        wr(`IMZ_CTRL_ADDR, 8'hA5);
        rd(`IMZ_CTRL_ADDR, 8'hA4, "control readback");
        wr(5'h02, 8'hFF);
        rd(`IMZ_CTRL_ADDR, 8'hA4, "stray write");
        rd(5'h02, 8'h00, "unmapped read");
        rd(`IMZ_STAT_ADDR, 8'h03, "idle status");
        $display("test regs done");
    endtask : t_regs

    task t_real;
        int r, m;
        slow <= 1'b0;
        for (r = 0; r < 4; r++)
            for (m = 0; m < 4; m++)
                t_mode(2'(r), 2'(m), 1'b0, 1'b0, 1'b0, 'h4000, -'h0F00);
        $display("test real done");
    endtask : t_real

    task t_stuff;
        int m;
        slow <= 1'b1;
        for (m = 0; m < 4; m++)
            t_mode(2'h3, 2'(m), 1'b1, 1'b0, 1'b0, -'h2345, 'h0777);
        slow <= 1'b0;
        $display("test stuffing done");
    endtask : t_stuff

    task t_cmix;
        t_mode(2'h2, 2'h2, 1'b0, 1'b1, 1'b0, 'h1000, 'h0800);
        t_mode(2'h2, 2'h2, 1'b0, 1'b1, 1'b1, 'h1000, 'h0800);
        t_mode(2'h1, 2'h3, 1'b1, 1'b1, 1'b0, 'h1000, 0);
        t_mode(2'h0, 2'h3, 1'b0, 1'b1, 1'b1, 'h1000, 0);
        t_mode(2'h1, 2'h1, 1'b0, 1'b1, 1'b0, 'h1000, 'h0800);
        $display("test complex done");
    endtask : t_cmix

    // Source outruns an eight-times stuffed drain, then stops altogether
    task t_flow;
        int n, hi;
        wr(`IMZ_CTRL_ADDR, 8'hC8);
        run <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        // One pop every 16 cycles opens exactly one cycle of room
        hi = 0;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys_i);
            #1 hi += ready;
        end
        check(16'(hi), 16'h0001, "full refuses");
        wr(`IMZ_STAT_ADDR, 8'h01);
        rd(`IMZ_STAT_ADDR, 8'h00, "underrun cleared");
        run <= 1'b0;
        repeat (120) @(posedge clk_sys_i);
        rd(`IMZ_STAT_ADDR, 8'h03, "underrun status");
        check(dac_i, 16'h8000, "starved output");
        $display("test flow done");
    endtask : t_flow

    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        sys_rst_i = 1'b1;
        reg_wr    = 1'b0;
        reg_addr  = `IMZ_CTRL_ADDR;
        reg_wdata = 8'h00;
        run       = 1'b0;
        slow      = 1'b0;
        si        = 16'h0000;
        sq        = 16'h0000;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 t_regs();
        t_real();
        t_stuff();
        t_cmix();
        t_flow();
        tally_and_finish();
    end
endmodule : test_imz_modulator

`default_nettype wire
